/* rdcr_pkg.sv */
package rdcr_pkg;

    // ==========================================================
    // Serial control port.
    localparam logic [5:0]  DEV_ADDR_TOP = 6'h0E;   // Upper six bits of the slave address.
    localparam logic [1:0]  X_BYTES      = 2'h3;    // Bytes per wide RAM word.
    localparam logic [1:0]  Y_BYTES      = 2'h2;    // Bytes per narrow RAM or register word.

    // ==========================================================
    // Memory map.
    localparam logic [15:0] X_BASE      = 16'h0000;
    localparam logic [15:0] X_LAST      = 16'h017F;
    localparam logic [15:0] Y_BASE      = 16'h0800;
    localparam logic [15:0] Y_LAST      = 16'h097F;
    localparam int          RAM_WORDS   = 384;
    localparam int          X_WIDTH     = 18;
    localparam int          Y_WIDTH     = 12;
    localparam int          REG_COUNT   = 8;

    localparam int IDX_RDC = 0;
    localparam int IDX_HPC = 1;
    localparam int IDX_INC = 2;
    localparam int IDX_IAB = 3;
    localparam int IDX_LIA = 4;
    localparam int IDX_CNV = 5;
    localparam int IDX_CSK = 6;
    localparam int IDX_CSC = 7;

    localparam logic [15:0] REG_ADDR [0:REG_COUNT-1] = '{
        16'h0FF3, 16'h0FF9, 16'h0FFA, 16'h0FFB, 16'h0FFC, 16'h0FFD, 16'h0FFE, 16'h0FFF};
    localparam logic [15:0] REG_RESET [0:REG_COUNT-1] = '{
        16'h0000, 16'hC000, 16'h1048, 16'h0AED, 16'h0080, 16'h006C, 16'h28ED, 16'hD323};
    localparam logic [15:0] REG_MASK [0:REG_COUNT-1] = '{
        16'hFFFF, 16'hFFFF, 16'hBBEE, 16'h8FFF, 16'hE0FF, 16'hF87F, 16'hFFFF, 16'hFFFF};

    // ==========================================================
    // Field positions and defaults.
    localparam int CSC_PLL_MSB  = 14;
    localparam int CSC_PLL_LSB  = 11;
    localparam int CSC_GAIN     = 9;
    localparam int CSC_F1_MSB   = 7;
    localparam int CSC_F1_LSB   = 4;
    localparam int CSC_F0_MSB   = 3;
    localparam int CSC_F0_LSB   = 0;
    localparam int CNV_MPX_MSB  = 6;
    localparam int CNV_MPX_LSB  = 4;
    localparam int CNV_RDS_MSB  = 3;
    localparam int CNV_RDS_LSB  = 1;
    localparam int CNV_TUNER    = 0;
    localparam int LIA_DYN_EN   = 15;
    localparam int LIA_DEV_MSB  = 14;
    localparam int LIA_DEV_LSB  = 13;
    localparam int LIA_STR_MSB  = 7;
    localparam int LIA_STR_LSB  = 6;
    localparam int LIA_FF_MSB   = 5;
    localparam int LIA_FF_LSB   = 4;
    localparam int LIA_THR_MSB  = 3;
    localparam int LIA_THR_LSB  = 0;

    localparam logic [3:0] PLL_DEF     = 4'hA;
    localparam logic [3:0] F1_DEF      = 4'h2;
    localparam logic [3:0] F0_DEF      = 4'h3;
    localparam logic [2:0] SENS_DEF    = 3'h6;
    localparam logic [1:0] STRETCH_DEF = 2'h2;

    // ==========================================================
    // Control port sequencing.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_RACK = 3'b010,
        ST_TX   = 3'b011,
        ST_TACK = 3'b100
    } rdcr_state_t;

    typedef enum logic [1:0] {
        PH_DEV     = 2'b00,
        PH_ADDR_HI = 2'b01,
        PH_ADDR_LO = 2'b10,
        PH_DATA    = 2'b11
    } rdcr_phase_t;

endpackage

/* rdcr_regs.sv */
`timescale 1ns/100ps
module rdcr_regs
    import rdcr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        scl_line,
    input  wire logic        sda_line,
    input  wire logic        addr_pin,
    output wire logic        sda_value,
    output wire logic        sda_oe,
    output wire logic [3:0]  pll_division_code,
    output wire logic        stereo_loop_gain,
    output wire logic [3:0]  coarse_factor_one,
    output wire logic [3:0]  coarse_factor_zero,
    output wire logic [15:0] sigma_delta_coefficient,
    output wire logic [2:0]  multiplex_input_sensitivity,
    output wire logic [2:0]  radio_data_input_sensitivity,
    output wire logic        tuner_count_choice,
    output wire logic        dynamic_absorber_enable,
    output wire logic [1:0]  dynamic_deviation_threshold,
    output wire logic [1:0]  absorber_stretch_time,
    output wire logic [1:0]  absorber_feed_forward,
    output wire logic [3:0]  absorber_threshold
);

    // ==========================================================
    // Line sampling and bus conditions.
    logic        scl_q;
    logic        sda_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;

    // Previous samples give edges; pins are already in the mclk domain.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_line;
            sda_q <= sda_line;
        end
    end

    // A data change while the clock stays high is a start or a stop.
    assign scl_rise  = scl_line & ~scl_q;
    assign scl_fall  = ~scl_line & scl_q;
    assign start_det = scl_line & scl_q & sda_q & ~sda_line;
    assign stop_det  = scl_line & scl_q & ~sda_q & sda_line;

    // ==========================================================
    // Port state.
    rdcr_state_t state_q,     state_d;
    rdcr_phase_t phase_q,     phase_d;
    logic [2:0]  bit_cnt_q,   bit_cnt_d;
    logic [7:0]  shift_q,     shift_d;
    logic        flag_q,      flag_d;
    logic        rw_q,        rw_d;
    logic [15:0] addr_q,      addr_d;
    logic [1:0]  byte_idx_q,  byte_idx_d;
    logic [15:0] wbuf_q,      wbuf_d;
    logic        sda_oe_q,    sda_oe_d;
    logic        sda_o_q;
    logic        commit;
    logic [23:0] wr_data;
    logic        x_we;
    logic        y_we;
    logic        reg_we;
    logic        in_x;
    logic        in_y;
    logic [1:0]  word_bytes;
    logic [23:0] rd_word;
    logic [7:0]  tx_byte;
    logic [15:0] rd_reg;

    logic [X_WIDTH-1:0] x_ram [0:RAM_WORDS-1];
    logic [Y_WIDTH-1:0] y_ram [0:RAM_WORDS-1];
    logic [15:0]        reg_q [0:REG_COUNT-1];
    logic [REG_COUNT-1:0] reg_hit;

    // Word length follows the address: the narrow half of the map and the
    // registers move two bytes, the wide RAM half three.
    assign in_x       = (addr_q <= X_LAST);
    assign in_y       = (addr_q >= Y_BASE) && (addr_q <= Y_LAST);
    assign word_bytes = (addr_q >= Y_BASE) ? Y_BYTES : X_BYTES;

    // Writes land only on mapped words; everything else is dropped.
    assign wr_data = {wbuf_q, shift_q};
    assign x_we    = commit && in_x;
    assign y_we    = commit && in_y;
    assign reg_we  = commit && (|reg_hit);

    // ==========================================================
    // Register file, one entry per mapped register.
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
        logic [15:0] nxt;
        assign reg_hit[i] = (addr_q == REG_ADDR[i]);

        // Reserved bits are masked on the way in, so they always read zero.
        always_comb begin
            nxt = reg_q[i];
            if (commit && reg_hit[i]) begin
                nxt = wr_data[15:0] & REG_MASK[i];
            end
        end

        always_ff @(posedge mclk) begin
            if (sys_rst) begin
                reg_q[i] <= REG_RESET[i];
            end else begin
                reg_q[i] <= nxt;
            end
        end
    end

    // Data RAMs hold no reset value; software loads them after start-up.
    always_ff @(posedge mclk) begin
        if (x_we) begin
            x_ram[addr_q[8:0]] <= wr_data[X_WIDTH-1:0];
        end
        if (y_we) begin
            y_ram[addr_q[8:0]] <= wr_data[Y_WIDTH-1:0];
        end
    end

    // ==========================================================
    // Read path; holes in the map read as zero.
    always_comb begin
        rd_reg = 16'h0000;
        for (int k = 0; k < REG_COUNT; k++) begin
            if (reg_hit[k]) begin
                rd_reg = reg_q[k];
            end
        end
        rd_word = {8'h00, rd_reg};
        if (in_x) begin
            rd_word = {6'h00, x_ram[addr_q[8:0]]};
        end else if (in_y) begin
            rd_word = {12'h000, y_ram[addr_q[8:0]]};
        end
    end

    // Most significant byte goes out first.
    always_comb begin
        tx_byte = rd_word[7:0];
        if (word_bytes == X_BYTES) begin
            case (byte_idx_q)
                2'h0:    tx_byte = rd_word[23:16];
                2'h1:    tx_byte = rd_word[15:8];
                default: tx_byte = rd_word[7:0];
            endcase
        end else if (byte_idx_q == 2'h0) begin
            tx_byte = rd_word[15:8];
        end
    end

    // ==========================================================
    // Serial sequencer. The flag marks a finished byte on receive and a
    // master acknowledge on transmit; both are acted on at the next fall.
    always_comb begin
        state_d    = state_q;
        phase_d    = phase_q;
        bit_cnt_d  = bit_cnt_q;
        shift_d    = shift_q;
        flag_d     = flag_q;
        rw_d       = rw_q;
        addr_d     = addr_q;
        byte_idx_d = byte_idx_q;
        wbuf_d     = wbuf_q;
        sda_oe_d   = sda_oe_q;
        commit     = 1'b0;
        if (start_det) begin
            state_d   = ST_RX;
            phase_d   = PH_DEV;
            bit_cnt_d = 3'h0;
            flag_d    = 1'b0;
            sda_oe_d  = 1'b0;
        end else if (stop_det) begin
            state_d  = ST_IDLE;
            flag_d   = 1'b0;
            sda_oe_d = 1'b0;
        end else begin
            case (state_q)
                ST_RX: begin
                    if (scl_rise) begin
                        shift_d   = {shift_q[6:0], sda_line};
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        flag_d    = (bit_cnt_q == 3'h7);
                    end else if (scl_fall && flag_q) begin
                        flag_d   = 1'b0;
                        state_d  = ST_RACK;
                        sda_oe_d = 1'b1;
                        case (phase_q)
                            PH_DEV: begin
                                byte_idx_d = 2'h0;
                                rw_d       = shift_q[0];
                                phase_d    = PH_ADDR_HI;
                                if (shift_q[7:1] != {DEV_ADDR_TOP, addr_pin}) begin
                                    state_d  = ST_IDLE;
                                    sda_oe_d = 1'b0;
                                end
                            end
                            PH_ADDR_HI: begin
                                addr_d[15:8] = shift_q;
                                phase_d      = PH_ADDR_LO;
                            end
                            PH_ADDR_LO: begin
                                addr_d[7:0] = shift_q;
                                phase_d     = PH_DATA;
                                byte_idx_d  = 2'h0;
                            end
                            default: begin
                                wbuf_d = {wbuf_q[7:0], shift_q};
                                if (byte_idx_q == word_bytes - 2'h1) begin
                                    commit     = 1'b1;
                                    byte_idx_d = 2'h0;
                                    addr_d     = addr_q + 16'h0001;
                                end else begin
                                    byte_idx_d = byte_idx_q + 2'h1;
                                end
                            end
                        endcase
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        bit_cnt_d = 3'h0;
                        if (rw_q) begin
                            state_d  = ST_TX;
                            shift_d  = tx_byte;
                            sda_oe_d = ~tx_byte[7];
                        end else begin
                            state_d  = ST_RX;
                            sda_oe_d = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == 3'h7) begin
                            state_d  = ST_TACK;
                            sda_oe_d = 1'b0;
                            if (byte_idx_q == word_bytes - 2'h1) begin
                                byte_idx_d = 2'h0;
                                addr_d     = addr_q + 16'h0001;
                            end else begin
                                byte_idx_d = byte_idx_q + 2'h1;
                            end
                        end else begin
                            bit_cnt_d = bit_cnt_q + 3'h1;
                            shift_d   = {shift_q[6:0], 1'b0};
                            sda_oe_d  = ~shift_q[6];
                        end
                    end
                end
                ST_TACK: begin
                    // A missing acknowledge ends the read and frees the line.
                    if (scl_rise) begin
                        flag_d = ~sda_line;
                        if (sda_line) begin
                            state_d = ST_IDLE;
                        end
                    end else if (scl_fall && flag_q) begin
                        flag_d    = 1'b0;
                        state_d   = ST_TX;
                        bit_cnt_d = 3'h0;
                        shift_d   = tx_byte;
                        sda_oe_d  = ~tx_byte[7];
                    end
                end
                default: begin
                    flag_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q    <= ST_IDLE;
            phase_q    <= PH_DEV;
            bit_cnt_q  <= 3'h0;
            shift_q    <= 8'h00;
            flag_q     <= 1'b0;
            rw_q       <= 1'b0;
            addr_q     <= 16'h0000;
            byte_idx_q <= 2'h0;
            wbuf_q     <= 16'h0000;
            sda_oe_q   <= 1'b0;
            sda_o_q    <= 1'b0;
        end else begin
            state_q    <= state_d;
            phase_q    <= phase_d;
            bit_cnt_q  <= bit_cnt_d;
            shift_q    <= shift_d;
            flag_q     <= flag_d;
            rw_q       <= rw_d;
            addr_q     <= addr_d;
            byte_idx_q <= byte_idx_d;
            wbuf_q     <= wbuf_d;
            sda_oe_q   <= sda_oe_d;
            sda_o_q    <= 1'b0;     // Open drain: only ever pulls low.
        end
    end

    // ==========================================================
    // Outputs, all taken from register flip-flops.
    assign sda_value = sda_o_q;
    assign sda_oe    = sda_oe_q;
    assign pll_division_code            = reg_q[IDX_CSC][CSC_PLL_MSB:CSC_PLL_LSB];
    assign stereo_loop_gain             = reg_q[IDX_CSC][CSC_GAIN];
    assign coarse_factor_one            = reg_q[IDX_CSC][CSC_F1_MSB:CSC_F1_LSB];
    assign coarse_factor_zero           = reg_q[IDX_CSC][CSC_F0_MSB:CSC_F0_LSB];
    assign sigma_delta_coefficient      = reg_q[IDX_CSK];
    assign multiplex_input_sensitivity  = reg_q[IDX_CNV][CNV_MPX_MSB:CNV_MPX_LSB];
    assign radio_data_input_sensitivity = reg_q[IDX_CNV][CNV_RDS_MSB:CNV_RDS_LSB];
    assign tuner_count_choice           = reg_q[IDX_CNV][CNV_TUNER];
    assign dynamic_absorber_enable      = reg_q[IDX_LIA][LIA_DYN_EN];
    assign dynamic_deviation_threshold  = reg_q[IDX_LIA][LIA_DEV_MSB:LIA_DEV_LSB];
    assign absorber_stretch_time        = reg_q[IDX_LIA][LIA_STR_MSB:LIA_STR_LSB];
    assign absorber_feed_forward        = reg_q[IDX_LIA][LIA_FF_MSB:LIA_FF_LSB];
    assign absorber_threshold           = reg_q[IDX_LIA][LIA_THR_MSB:LIA_THR_LSB];

    // ==========================================================
    // Checks.
    property p_core_write;
        @(posedge mclk) disable iff (sys_rst)
        (commit && addr_q == REG_ADDR[IDX_CNV])
            |=> reg_q[IDX_CNV] == ($past(wr_data[15:0]) & REG_MASK[IDX_CNV]);
    endproperty
    a_core_write: assert property (p_core_write) else $error("write not stored");

    property p_ram_range;
        @(posedge mclk) disable iff (sys_rst)
        (x_we |-> addr_q <= 16'h017F) and (y_we |-> addr_q[15:8] inside {8'h08, 8'h09});
    endproperty
    a_ram_range: assert property (p_ram_range) else $error("RAM write misplaced");

    property p_pll_default;
        @(posedge mclk) disable iff (sys_rst)
        $fell(sys_rst) |-> pll_division_code == 4'hA;
    endproperty
    a_pll_default: assert property (p_pll_default) else $error("PLL default wrong");

    property p_gain_default;
        @(posedge mclk) disable iff (sys_rst)
        $fell(sys_rst) |-> stereo_loop_gain && coarse_factor_one == 4'h2;
    endproperty
    a_gain_default: assert property (p_gain_default) else $error("gain default");

    property p_coarse_default;
        @(posedge mclk) disable iff (sys_rst)
        $fell(sys_rst) |-> coarse_factor_zero == 4'h3 && sigma_delta_coefficient == 16'h28ED;
    endproperty
    a_coarse_default: assert property (p_coarse_default) else $error("coarse reset");

    property p_conv_default;
        @(posedge mclk) disable iff (sys_rst)
        $fell(sys_rst) |-> reg_q[IDX_CNV] == 16'h006C && reg_q[IDX_LIA] == 16'h0080;
    endproperty
    a_conv_default: assert property (p_conv_default) else $error("converter reset");

    property p_reserved_zero;
        @(posedge mclk) disable iff (sys_rst)
        reg_q[IDX_CNV][10:7] == 4'h0 && reg_q[IDX_LIA][12:8] == 5'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

    property p_byte_count;
        @(posedge mclk) disable iff (sys_rst)
        (x_we |-> byte_idx_q == 2'h2) and ((y_we || reg_we) |-> byte_idx_q == 2'h1);
    endproperty
    a_byte_count: assert property (p_byte_count) else $error("word length wrong");

    property p_addr_step;
        @(posedge mclk) disable iff (sys_rst)
        commit |=> addr_q == $past(addr_q) + 16'h0001 && byte_idx_q == 2'h0;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("no address step");

    property p_ack_drive;
        @(posedge mclk) disable iff (sys_rst)
        (state_q == ST_RX && scl_fall && flag_q && phase_q != PH_DEV) |=> sda_oe_q;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("no acknowledge driven");

endmodule // rdcr_regs

/* rdcr_host_model.sv */
`timescale 1ns/100ps
// ==========================================================
// Host controller on the serial control lines; sda is open drain.
module rdcr_host_model (
    input  wire logic mclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // Both lines start high: scl is driven high and sda is released, so the pull-up shows it high.
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // Start (s=1) or stop (s=0); sda is set up before scl rises, then moves while scl is high.
    task automatic cond(input logic s);
        sda_low = ~s;
        repeat (4) @(negedge mclk);
        scl = 1'b1;
        repeat (4) @(negedge mclk);
        sda_low = s;
        repeat (4) @(negedge mclk);
        scl = ~s;
    endtask
    // One byte MSB first plus the ninth bit; each phase lasts four cycles,
    // above the slave's minimum of three, and the line is sampled mid-high.
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        logic [8:0] b;
        b = {tx, ack_in};
        for (int i = 8; i >= 0; i--) begin
            sda_low = ~b[i];
            repeat (4) @(negedge mclk);
            scl = 1'b1;
            repeat (2) @(negedge mclk);
            b[i] = sda_line;
            repeat (2) @(negedge mclk);
            scl = 1'b0;
        end
        rx  = b[8:1];
        ack = b[0];
    endtask
endmodule // rdcr_host_model

/* rdcr_regs_tb_top.sv */
`timescale 1ns/100ps
// ==========================================================
// Bench for the control register map behind its serial port.
module rdcr_regs_tb_top;
    import rdcr_pkg::*;
    localparam logic [15:0] WA [0:9] = '{16'h0FFD, 16'h0FFC, 16'h0FFF, 16'h0FFE, 16'h1000,
        16'h0FF4, 16'h0800, 16'h097F, 16'h017F, 16'h0000};
    localparam logic [23:0] WD [0:9] = '{24'h1FFF, 24'hFFFF, 24'h2C5A, 24'h1234, 24'hBEEF,
        24'hFFFF, 24'hFABC, 24'h0123, 24'hABCDEF, 24'h000001};
    localparam logic [23:0] RX [0:9] = '{24'h187F, 24'hE0FF, 24'h2C5A, 24'h1234, 24'h0,
        24'h0, 24'h0ABC, 24'h0123, 24'h03CDEF, 24'h000001};
    localparam logic [15:0] DA [0:3] = '{16'h0FFF, 16'h0FFE, 16'h0FFD, 16'h0FFC};
    localparam logic [15:0] DX [0:3] = '{16'hD323, 16'h28ED, 16'h006C, 16'h0080};
    logic        mclk, sys_rst, addr_pin, scl, sda_low, sda_o, sda_oe, gain, tun, dyn, k;
    logic [1:0]  dth, str, ff;
    logic [2:0]  mpx, rds;
    logic [3:0]  pll, f1, f0, thr;
    logic [7:0]  dev_w;
    logic [15:0] sdc;
    logic [23:0] v;
    int          n_errors = 0, n_compared = 0, cyc = 0;
    // The data wire is pulled up; either party may pull it low.
    wire sda_line = ~(sda_low | (sda_oe & ~sda_o));
    rdcr_regs rdcr_regs_i (.mclk(mclk), .sys_rst(sys_rst), .scl_line(scl), .sda_line(sda_line),
        .addr_pin(addr_pin), .sda_value(sda_o), .sda_oe(sda_oe), .pll_division_code(pll),
        .stereo_loop_gain(gain), .coarse_factor_one(f1), .coarse_factor_zero(f0),
        .sigma_delta_coefficient(sdc), .multiplex_input_sensitivity(mpx),
        .radio_data_input_sensitivity(rds), .tuner_count_choice(tun),
        .dynamic_absorber_enable(dyn), .dynamic_deviation_threshold(dth),
        .absorber_stretch_time(str), .absorber_feed_forward(ff), .absorber_threshold(thr));
    rdcr_host_model rdcr_host_model_i (.mclk(mclk), .sda_line(sda_line), .scl(scl),
        .sda_low(sda_low));
    // Clock at 200 MHz.
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // A full run needs about 13300 cycles; three times that means a hang.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One word access; the byte count follows the address, and nk gathers every ack.
    task automatic acc(input logic [15:0] a, input logic [23:0] d, input logic rd_en,
                       output logic [23:0] q, output logic nk);
        logic [7:0] r;
        logic       k0, k1, k2;
        q = '0;
        rdcr_host_model_i.cond(1'b1);
        rdcr_host_model_i.xfer(dev_w, 1'b1, r, k0);
        rdcr_host_model_i.xfer(a[15:8], 1'b1, r, k1);
        rdcr_host_model_i.xfer(a[7:0], 1'b1, r, k2);
        nk = k0 | k1 | k2;
        if (rd_en) begin
            rdcr_host_model_i.cond(1'b1);
            rdcr_host_model_i.xfer(dev_w | 8'h01, 1'b1, r, k0);
            nk = nk | k0;
        end
        for (int i = ((a < Y_BASE) ? 2 : 1); i >= 0; i--) begin
            rdcr_host_model_i.xfer(rd_en ? 8'hFF : d[8*i+:8], rd_en ? (i == 0) : 1'b1, r, k0);
            q[8*i+:8] = r;
            nk = nk | (k0 & ~rd_en);
        end
        rdcr_host_model_i.cond(1'b0);
    endtask
    task automatic chk_def();
        chk({pll, gain, f1, f0}, {4'hA, 1'b1, 4'h2, 4'h3});
        chk({mpx, rds, tun}, {3'h6, 3'h6, 1'b0});
        chk({dyn, dth, str, ff, thr}, {1'b0, 2'h0, 2'h2, 2'h0, 4'h0});
        for (int i = 0; i < 4; i++) begin
            acc(DA[i], 24'h0, 1'b1, v, k);
            chk(v, DX[i]);
        end
    endtask
    task automatic results();
        $display("compared=%0d errors=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence; inputs move only just after falling edges.
    initial begin
        sys_rst  = 1'b1;
        addr_pin = 1'b0;
        dev_w    = 8'h38;
        repeat (8) @(negedge mclk);
        sys_rst = 1'b0;
        chk_def();
        $display("test defaults done");
        for (int i = 0; i < 10; i++) begin
            acc(WA[i], WD[i], 1'b0, v, k);
            chk(k, 1'b0);
            acc(WA[i], 24'h0, 1'b1, v, k);
            chk(v, RX[i]);
            chk(k, 1'b0);
        end
        chk({pll, gain, f1, f0}, {4'h5, 1'b0, 4'h5, 4'hA});
        chk({mpx, rds, tun}, {3'h7, 3'h7, 1'b1});
        chk({dyn, dth, str, ff, thr}, {1'b1, 2'h3, 2'h3, 2'h3, 4'hF});
        chk(sdc, 16'h1234);
        $display("test write read done");
        dev_w = 8'h3A;
        acc(16'h0FFE, 24'h0, 1'b0, v, k);
        chk(k, 1'b1);
        chk(sdc, 16'h1234);
        addr_pin = 1'b1;
        acc(16'h0FFE, 24'h28ED, 1'b0, v, k);
        chk(sdc, 16'h28ED);
        $display("test address select done");
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        chk_def();
        $display("test second reset done");
        results();
    end
endmodule // rdcr_regs_tb_top
